/* File: logic/sfs_pkg.sv */
// Purpose: Shared constants and types of the supply fault supervisor
// Assumes: 25 MHz core clock; interval counters run on a 1 us tick, input filters on clock cycles
// Notes:   Interval figures are kept in their own units, tick counts derive
package sfs_pkg;

    // Core clock and timebase
    localparam int unsigned CLK_HZ     = 25_000_000;   // Core clock rate
    localparam int unsigned US_PER_S   = 1_000_000;    // Microseconds per second
    localparam int unsigned TICK_CYC   = CLK_HZ / US_PER_S; // Cycles per 1 us tick
    localparam int unsigned TICK_W     = 5;            // Width of tick prescaler

    // Interval figures as printed
    localparam int unsigned BLANK_MS   = 64;           // Start-up blanking
    localparam int unsigned PGOOD_MS   = 250;          // Power-good delay
    localparam int unsigned OFF_US     = 2500;         // Turn-off delay, 2.5 ms
    localparam int unsigned RETRY_S    = 1;            // Bounce retry wait

    // Interval lengths in 1 us ticks
    localparam int unsigned BLANK_TICKS = BLANK_MS * 1000;
    localparam int unsigned PGOOD_TICKS = PGOOD_MS * 1000;
    localparam int unsigned OFF_TICKS   = OFF_US;
    localparam int unsigned RETRY_TICKS = RETRY_S * US_PER_S;

    // Input filter length in clock cycles
    localparam int unsigned DEB_CYC    = 8;

    // Comparator results and request pins, one bit each
    typedef struct packed {
        logic main_overvoltage_trip;    // Any main rail above OV
        logic main_undervoltage_trip;   // Any main rail below UV
        logic aux_overvoltage_trip;     // Aux monitor above OV
        logic aux_undervoltage_trip;    // Aux monitor below UV
        logic supply_overvoltage_trip;  // Chip supply above OV
        logic line_sense_in;            // High: line input valid
        logic supply_on_request;        // High: turn-off request
        logic supply_lockout;           // High: chip supply too low
    } sfs_mon_t;

    localparam int unsigned MON_W = $bits(sfs_mon_t);

    // Filter start values: safe, locked out, off requested
    localparam sfs_mon_t MON_RST = 8'h03;

endpackage : sfs_pkg

/* File: logic/sfs_supervisor.sv */
// Purpose: Fault latches, sequencing and power-good of the supply supervisor
// Assumes: All inputs synchronous to i_mclk; comparators already digitised
// Notes:   Every interval timer but the input filters counts one shared 1 us tick; filters count cycles
`timescale 1ns/10ps
module sfs_supervisor
    import sfs_pkg::*;
#(
    parameter int unsigned DEB_LEN   = DEB_CYC,      // Filter length, cycles
    parameter int unsigned BLANK_LEN = BLANK_TICKS,  // Blanking, ticks
    parameter int unsigned PGOOD_LEN = PGOOD_TICKS,  // Power-good delay, ticks
    parameter int unsigned OFF_LEN   = OFF_TICKS,    // Turn-off delay, ticks
    parameter int unsigned RETRY_LEN = RETRY_TICKS   // Bounce wait, ticks
) (
    // Clock and reset
    input  wire logic     i_mclk,
    input  wire logic     i_rst_n,
    // Comparators and requests
    input  wire sfs_mon_t i_mon,
    // Option: high selects bounce mode
    input  wire logic     i_bounce_mode,
    // Converter control
    output logic          o_main_fault_out,
    output logic          o_aux_fault_out,
    output logic          o_aux_loop_pulldown,
    // System status
    output logic          o_power_good_out
);

    // Filter and timebase state
    sfs_mon_t            filt;           // Filtered inputs
    logic [MON_W-1:0]    flip;           // Filter terminal per bit
    logic                live;           // Chip supply valid
    logic [TICK_W-1:0]   tick_cnt;       // Tick prescaler
    logic                tick;           // 1 us strobe
    logic                line_seen;      // Line valid seen once
    logic                aux_blank_done; // Aux blanking over
    logic                main_blank_done;// Main blanking over
    logic                off_done;       // Turn-off delay over
    logic                retry_done;     // Bounce wait over
    logic                pg_done;        // Power-good delay over
    logic                all_good;       // Conditions for power-good
    // Fault latches, detection terms and the main fault source
    logic                ov_latch;       // Main OV
    logic                uv_latch;       // Main UV
    logic                aux_ov_latch;   // Aux OV
    logic                aux_uv_latch;   // Aux UV
    logic                sup_ov_latch;   // Supply OV
    logic                ov_set;         // Main OV detection
    logic                uv_set;         // Main UV detection
    logic                next_main_fault;// Main fault next value

    // Input filtering: a bit flips only after DEB_LEN steady cycles
    genvar gi;
    generate
        for (gi = 0; gi < MON_W; gi++) begin : g_deb
            sfs_timer #(
                .LIMIT (DEB_LEN)
            ) u_deb (
                .i_mclk  (i_mclk),
                .i_rst_n (i_rst_n),
                .i_run   (i_mon[gi] != filt[gi]),
                .i_tick  (1'b1),
                .o_done  (flip[gi])
            );
        end
    endgenerate

    // Filtered value register; a glitch shorter than the filter is lost
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            filt <= MON_RST;
        end else begin
            filt <= filt ^ flip;
        end
    end

    // Supply valid once the filtered lockout has gone
    assign live = !filt.supply_lockout;

    // Single timebase, held in reset by the lockout
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (!live) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_W'(TICK_CYC - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // Line valid memory: main blanking starts on the first valid report
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_seen <= 1'b0;
        end else if (!live) begin
            line_seen <= 1'b0;
        end else if (filt.line_sense_in) begin
            line_seen <= 1'b1;
        end
    end

    // Aux blanking starts as the chip supply becomes valid
    sfs_timer #(
        .LIMIT (BLANK_LEN)
    ) u_aux_blank (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (live),
        .i_tick  (tick),
        .o_done  (aux_blank_done)
    );

    // Main blanking restarts on every converter enable, also after a retry
    sfs_timer #(
        .LIMIT (BLANK_LEN)
    ) u_main_blank (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (live && line_seen && !o_main_fault_out),
        .i_tick  (tick),
        .o_done  (main_blank_done)
    );

    // Turn-off delay runs while the off request stands
    sfs_timer #(
        .LIMIT (OFF_LEN)
    ) u_off (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (live && filt.supply_on_request),
        .i_tick  (tick),
        .o_done  (off_done)
    );

    // Bounce wait runs while a UV fault is held in bounce mode
    sfs_timer #(
        .LIMIT (RETRY_LEN)
    ) u_retry (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (live && uv_latch && i_bounce_mode),
        .i_tick  (tick),
        .o_done  (retry_done)
    );

    // Power-good delay restarts whenever any condition drops
    sfs_timer #(
        .LIMIT (PGOOD_LEN)
    ) u_pgood (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (all_good),
        .i_tick  (tick),
        .o_done  (pg_done)
    );

    // Detection terms; UV needs a valid line and finished blanking
    assign ov_set = filt.main_overvoltage_trip;
    assign uv_set = filt.main_undervoltage_trip && filt.line_sense_in
                    && main_blank_done;

    // Main OV latch: set wins over the clearing request cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ov_latch <= 1'b0;
        end else if (!live) begin
            ov_latch <= 1'b0;
        end else begin
            ov_latch <= ov_set || (ov_latch && !filt.supply_on_request);
        end
    end

    // Main UV latch: bounce wait or request cycle releases it
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            uv_latch <= 1'b0;
        end else if (!live) begin
            uv_latch <= 1'b0;
        end else begin
            uv_latch <= uv_set || (uv_latch && !retry_done
                        && !filt.supply_on_request);
        end
    end

    // Aux and supply OV latches; only the lockout clears them
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aux_ov_latch <= 1'b0;
            sup_ov_latch <= 1'b0;
        end else if (!live) begin
            aux_ov_latch <= 1'b0;
            sup_ov_latch <= 1'b0;
        end else begin
            aux_ov_latch <= aux_ov_latch || filt.aux_overvoltage_trip;
            sup_ov_latch <= sup_ov_latch || filt.supply_overvoltage_trip;
        end
    end

    // Aux UV latch, blanked during start-up
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aux_uv_latch <= 1'b0;
        end else if (!live) begin
            aux_uv_latch <= 1'b0;
        end else if (filt.aux_undervoltage_trip && aux_blank_done) begin
            aux_uv_latch <= 1'b1;
        end
    end

    // Main fault sources
    assign next_main_fault = !live || ov_latch || uv_latch
                             || aux_ov_latch || aux_uv_latch
                             || sup_ov_latch || off_done;

    // Power-good conditions; an off request removes it at once
    assign all_good = live && !filt.supply_on_request
                      && !o_main_fault_out && filt.line_sense_in
                      && !filt.main_undervoltage_trip
                      && !filt.aux_undervoltage_trip;

    // Output flops; reset and lockout give the off levels
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_main_fault_out    <= 1'b1;
            o_aux_fault_out     <= 1'b0;
            o_aux_loop_pulldown <= 1'b0;
            o_power_good_out    <= 1'b0;
        end else begin
            o_main_fault_out    <= next_main_fault;
            o_aux_fault_out     <= live && (aux_ov_latch || sup_ov_latch);
            o_aux_loop_pulldown <= live && aux_uv_latch;
            o_power_good_out    <= all_good && pg_done;
        end
    end

    // Checks next to the logic they guard
    // They see registered state, so most allow one edge of output latency
    main_ov_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (live && filt.main_overvoltage_trip) |=> ##1 o_main_fault_out)
        else $error("main OV did not raise main fault");

    ov_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ov_latch && live && !filt.supply_on_request) |=> ov_latch)
        else $error("main OV latch released without request cycle");

    brownout_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!filt.line_sense_in && !uv_latch) |=> !uv_latch)
        else $error("UV latched during brownout");

    uv_blank_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!main_blank_done && !uv_latch) |=> !uv_latch)
        else $error("UV latched inside blanking");

    retry_rel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (uv_latch && retry_done && !uv_set) |=> !uv_latch)
        else $error("bounce wait did not release UV");

    pg_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        filt.supply_on_request |=> !o_power_good_out)
        else $error("power-good stayed high on off request");

    pg_delay_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_power_good_out) |-> $past(pg_done) && $past(all_good))
        else $error("power-good rose before its delay");

    off_delay_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (live && off_done) |=> o_main_fault_out)
        else $error("turn-off delay did not raise main fault");

    aux_ov_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (live && filt.aux_overvoltage_trip) |=> ##1 (o_aux_fault_out && o_main_fault_out))
        else $error("aux OV did not latch both faults");

    sup_ov_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (live && sup_ov_latch) |=> (o_aux_fault_out && o_main_fault_out))
        else $error("supply OV did not latch both faults");

    aux_uv_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (live && aux_uv_latch) |=> (o_aux_loop_pulldown && o_main_fault_out))
        else $error("aux UV did not pull loop drive low");

    lockout_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !live |=> (o_main_fault_out && !o_power_good_out && !o_aux_fault_out))
        else $error("outputs not off during lockout");

    lock_clr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !live |=> !(ov_latch || uv_latch || aux_ov_latch || sup_ov_latch))
        else $error("lockout did not clear latches");

    tick_rst_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !live |=> (tick_cnt == '0 && !tick))
        else $error("timebase ran during lockout");

    uv_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (live && uv_latch && !i_bounce_mode && !filt.supply_on_request) |=> uv_latch)
        else $error("latch-mode UV released without request cycle");

    filt_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_mon == filt) |=> (filt == $past(filt)))
        else $error("filtered input moved without a raw change");

    aux_uv_blank_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!aux_blank_done && !aux_uv_latch) |=> !aux_uv_latch)
        else $error("aux UV latched inside blanking");

    main_blank_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !line_seen |=> !main_blank_done)
        else $error("main blanking ended before line was valid");

    aux_blank_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !live |=> !aux_blank_done)
        else $error("aux blanking ended before supply was valid");

    pg_main_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_power_good_out |-> !$past(o_main_fault_out))
        else $error("power-good high while main converter was off");

endmodule : sfs_supervisor

/* File: logic/sfs_timer.sv */
// Purpose: Run-gated tick counter with a terminal flag
// Assumes: i_tick is a one-cycle strobe, or tied high to count cycles
// Notes:   Dropping i_run drops o_done at once; the count clears next edge
`timescale 1ns/10ps
module sfs_timer #(
    parameter int unsigned LIMIT = 4,                  // Ticks to terminal
    parameter int unsigned CW    = $clog2(LIMIT + 1)   // Counter width
) (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // Control
    input  wire logic i_run,
    input  wire logic i_tick,
    // Status
    output logic      o_done
);

    logic [CW-1:0] cnt;                                // Elapsed ticks

    // Count while running, hold at terminal
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
        end else if (!i_run) begin
            cnt <= '0;
        end else if (i_tick && !o_done) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Terminal reached; gated by i_run so a stopped timer never shows a stale done
    assign o_done = i_run && (cnt == CW'(LIMIT));

endmodule : sfs_timer

/* File: test/sfs_plant.sv */
// Purpose: Far-side model: host request, line sense and main converter rails
// Assumes: Bench commands the levels; rails sag while the main converter is off
// Notes:   Rail settle must stay shorter than the main blanking interval
`timescale 1ns/10ps
module sfs_plant
    import sfs_pkg::*;
#(
    parameter int unsigned RAMP = 100        // Cycles for rails to settle
) (
    // Clock
    input  wire logic     i_mclk,
    // Converter control from the supervisor
    input  wire logic     i_main_fault_out,
    // Bench command levels
    input  wire sfs_mon_t i_cmd,
    // Comparator results seen by the supervisor
    output sfs_mon_t      o_mon
);
    logic [7:0] ramp_cnt = 8'h00;            // Cycles since converter enabled

    // Rails restart from zero each time the converter is stopped
    always_ff @(posedge i_mclk) begin
        if (i_main_fault_out) begin
            ramp_cnt <= 8'h00;
        end else if (ramp_cnt < 8'(RAMP)) begin
            ramp_cnt <= ramp_cnt + 8'h01;
        end
    end

    // Undervoltage shows while rails are still rising, no kinder than reality
    always_comb begin
        o_mon = i_cmd;
        o_mon.main_undervoltage_trip = i_cmd.main_undervoltage_trip | (ramp_cnt < 8'(RAMP));
    end
endmodule : sfs_plant

/* File: test/supply_fault_supervisor_test.sv */
// Purpose: Self-checking bench of the supply fault supervisor
// Assumes: Shortened intervals; plant model closes the main converter loop
// Notes:   Windows allow for filter delay and the 1 us tick phase
`timescale 1ns/10ps
module supply_fault_supervisor_test;
    import sfs_pkg::*;
    localparam int DEB = 2;                  // Filter length set below
    localparam int RAMP = 100;               // Plant rail settle, cycles
    localparam int PG_C = 30 * TICK_CYC;     // Power-good delay, cycles
    localparam int OFF_C = 10 * TICK_CYC;    // Turn-off delay, cycles
    localparam int RT_C = 40 * TICK_CYC;     // Bounce wait, cycles
    localparam int BOOT_C = RAMP + PG_C;     // Rail settle plus power-good delay
    localparam int LIMIT = 40000;            // Run ceiling, cycles
    localparam int B_MOV = 7, B_MUV = 6, B_AOV = 5, B_AUV = 4;
    localparam int B_SOV = 3, B_LINE = 2, B_REQ = 1, B_LOCK = 0;
    logic     i_mclk = 1'b0;                 // Core clock
    logic     i_rst_n = 1'b0;                // Reset, active low
    logic     bounce = 1'b0;                 // Retry option
    sfs_mon_t cmd = MON_RST;                 // Commanded levels
    sfs_mon_t mon;                           // Levels after the plant
    logic     main_f, aux_f, pull_d, pgood;  // Design outputs
    int       failures = 0;
    int       n_compared = 0;
    int       cyc = 0;

    sfs_plant #(.RAMP(RAMP)) plant (.i_mclk(i_mclk), .i_main_fault_out(main_f),
        .i_cmd(cmd), .o_mon(mon));
    sfs_supervisor #(.DEB_LEN(DEB), .BLANK_LEN(20), .PGOOD_LEN(30), .OFF_LEN(10),
        .RETRY_LEN(40)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mon(mon),
        .i_bounce_mode(bounce), .o_main_fault_out(main_f), .o_aux_fault_out(aux_f),
        .o_aux_loop_pulldown(pull_d), .o_power_good_out(pgood));

    // Clock, 40 ns period
    initial begin
        forever #20 i_mclk = ~i_mclk;
    end

    // Hang guard
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            $display("BAD %0t run ceiling reached", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    function automatic logic outb(input int sel);
        case (sel)
            0: return main_f;
            1: return aux_f;
            2: return pull_d;
            default: return pgood;
        endcase
    endfunction : outb

    task automatic chk(input string what, input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : chk

    task automatic chk_rng(input string what, input int n, input int lo, input int hi);
        n_compared++;
        if (n < lo || n > hi) begin
            failures++;
            $display("BAD %0t %s took %0d", $time, what, n);
        end
    endtask : chk_rng

    // Bounded wait for an output level, counting edges
    task automatic waitf(input int sel, input logic v, input int mx, output int n);
        n = 0;
        while (outb(sel) !== v && n < mx) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
    endtask : waitf

    task automatic stay(input int sel, input logic v, input int c, output logic ok);
        ok = 1'b1;
        repeat (c) begin
            @(posedge i_mclk);
            #1;
            if (outb(sel) !== v) ok = 1'b0;
        end
    endtask : stay

    // Raise a level for c cycles, then let c more pass
    task automatic pulse(input int b, input int c);
        @(posedge i_mclk);
        cmd[b] <= 1'b1;
        repeat (c) @(posedge i_mclk);
        cmd[b] <= 1'b0;
        repeat (c) @(posedge i_mclk);
        #1;
    endtask : pulse

    // Raise a trip, time the output response, then drop the trip
    task automatic trip(input int b, input int sel, input string what);
        int n;
        @(posedge i_mclk);
        cmd[b] <= 1'b1;
        #1;
        waitf(sel, 1'b1, 20, n);
        chk_rng(what, n, DEB + 2, DEB + 4);
        @(posedge i_mclk);
        cmd[b] <= 1'b0;
        #1;
    endtask : trip

    // Supply valid, line valid, request low; converter must come up
    task automatic boot();
        int n;
        @(posedge i_mclk);
        cmd[B_LOCK] <= 1'b0;
        cmd[B_REQ] <= 1'b0;
        cmd[B_LINE] <= 1'b1;
        #1;
        waitf(0, 1'b0, 200, n);
        chk("main fault released", main_f, 1'b0);
        waitf(3, 1'b1, RAMP + PG_C + 100, n);
        chk_rng("power good delay", n, BOOT_C - TICK_CYC - 5, BOOT_C + 10);
    endtask : boot

    task automatic t_lockout();
        logic ok;
        for (int s = 0; s < 4; s++) begin
            stay(s, s == 0, 10, ok);
            chk("default off level", ok, 1'b1);
        end
    endtask : t_lockout

    task automatic t_off();
        int n;
        @(posedge i_mclk);
        cmd[B_REQ] <= 1'b1;
        #1;
        waitf(3, 1'b0, 20, n);
        chk_rng("power good drop", n, DEB + 1, DEB + 3);
        waitf(0, 1'b1, OFF_C + 100, n);
        chk_rng("turn-off delay", n, OFF_C - TICK_CYC, OFF_C + 5);
        boot();
    endtask : t_off

    task automatic t_glitch();
        logic ok;
        pulse(B_REQ, DEB);
        stay(3, 1'b1, 20, ok);
        chk("request glitch", ok, 1'b1);
        pulse(B_MOV, DEB);
        stay(0, 1'b0, 20, ok);
        chk("trip glitch", ok, 1'b1);
    endtask : t_glitch

    task automatic t_latch(input int b, input int c);
        logic ok;
        trip(b, 0, "trip to main fault");
        stay(0, 1'b1, c, ok);
        chk("main fault latched", ok, 1'b1);
        @(posedge i_mclk);
        cmd[B_REQ] <= 1'b1;
        repeat (OFF_C + 2 * TICK_CYC) @(posedge i_mclk);
        boot();
    endtask : t_latch

    task automatic t_brownout();
        int n;
        logic ok;
        @(posedge i_mclk);
        cmd[B_LINE] <= 1'b0;
        cmd[B_MUV] <= 1'b1;
        stay(0, 1'b0, 200, ok);
        chk("brownout undervoltage", ok, 1'b1);
        @(posedge i_mclk);
        cmd[B_LINE] <= 1'b1;
        cmd[B_MUV] <= 1'b0;
        #1;
        waitf(3, 1'b1, PG_C + 100, n);
        chk_rng("power good after brownout", n, PG_C - TICK_CYC, PG_C + 10);
    endtask : t_brownout

    task automatic t_bounce();
        int n;
        @(posedge i_mclk);
        bounce <= 1'b1;
        trip(B_MUV, 0, "undervoltage to main fault");
        waitf(0, 1'b0, RT_C + 100, n);
        chk_rng("bounce retry", n, RT_C - TICK_CYC, RT_C + 5);
        boot();
        @(posedge i_mclk);
        bounce <= 1'b0;
    endtask : t_bounce

    task automatic t_aux();
        int n;
        logic ok;
        @(posedge i_mclk);
        cmd[B_LOCK] <= 1'b1;
        #1;
        waitf(3, 1'b0, 20, n);
        chk_rng("lockout drops power good", n, DEB + 1, DEB + 4);
        waitf(0, 1'b1, 4, n);
        chk("lockout raises main fault", main_f, 1'b1);
        @(posedge i_mclk);
        cmd[B_LOCK] <= 1'b0;
        cmd[B_AUV] <= 1'b1;
        stay(2, 1'b0, 200, ok);
        chk("aux undervoltage blanked", ok, 1'b1);
        @(posedge i_mclk);
        cmd[B_AUV] <= 1'b0;
        #1;
        waitf(3, 1'b1, PG_C + 400, n);
        chk("power good up", pgood, 1'b1);
        trip(B_AUV, 2, "aux undervoltage pulldown");
        chk("aux undervoltage main fault", main_f, 1'b1);
        chk("aux fault stays low", aux_f, 1'b0);
        stay(2, 1'b1, 200, ok);
        chk("pulldown latched", ok, 1'b1);
        pulse(B_LOCK, 10);
        chk("lockout clears pulldown", pull_d, 1'b0);
        trip(B_AOV, 1, "aux overvoltage immediate");
        chk("aux overvoltage main fault", main_f, 1'b1);
        stay(1, 1'b1, 100, ok);
        chk("aux fault latched", ok, 1'b1);
        pulse(B_LOCK, 10);
        chk("lockout clears aux fault", aux_f, 1'b0);
        trip(B_SOV, 1, "supply overvoltage");
        chk("supply overvoltage main fault", main_f, 1'b1);
        stay(1, 1'b1, 50, ok);
        chk("supply overvoltage latched", ok, 1'b1);
        pulse(B_LOCK, 10);
        chk("lockout clears supply trip", aux_f, 1'b0);
    endtask : t_aux

    // Main sequence
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_lockout();
        boot();
        t_off();
        t_glitch();
        t_latch(B_MOV, 300);
        t_latch(B_MUV, RT_C + 200);
        t_brownout();
        t_bounce();
        t_aux();
        conclude();
    end
endmodule : supply_fault_supervisor_test
